// *** shared/pcc_consts.svh ***
/*
  constants for the pc card memory cycle ends: widths, timing counts.
  assumes inclusion by bare name from any design file.
*/
`ifndef PCC_CONSTS_SVH
`define PCC_CONSTS_SVH
`define PCC_ADDR_W        26
`define PCC_DATA_W        16
`define PCC_MEM_AW        8
`define PCC_CLK_NS        25
`define PCC_SETUP_NS      100
`define PCC_SETUP_CYC     ((`PCC_SETUP_NS + `PCC_CLK_NS - 1) / `PCC_CLK_NS)
`define PCC_ACCESS_CYC    2
`define PCC_WAIT_HOLD_CYC 12
`define PCC_CFG_RESET     8'h00
`endif

// *** shared/pcc_pkg.sv ***
/*
  types shared by the pc card card end and host end.
  assumes pcc_consts.svh on the include path.
*/
`include "pcc_consts.svh"
package pcc_pkg;
  typedef logic [`PCC_ADDR_W-1:0] addr_t;
  typedef logic [`PCC_DATA_W-1:0] data_t;
  typedef enum logic [1:0] {
    SP_COMMON = 2'h0,
    SP_ATTR   = 2'h1,
    SP_IO     = 2'h2
  } space_t;
endpackage : pcc_pkg

// *** shared/pcc_if.sv ***
/*
  pc card bus wires between host socket and card.
  resolves data here from the host and card enables.
*/
`timescale 1ns/1ps
interface pcc_if;
  import pcc_pkg::*;
  addr_t addr;
  logic  ce1_n;
  logic  ce2_n;
  logic  reg_n;
  logic  oe_n;
  logic  we_n;
  logic  wait_n;
  logic  reset;
  data_t d_host;
  logic  d_host_oe;
  data_t d_card;
  logic  [1:0] d_card_oe;
  data_t d;
  always_comb begin
    d = d_host_oe ? d_host : 16'hffff;
    if (d_card_oe[0]) d[7:0] = d_card[7:0];
    if (d_card_oe[1]) d[15:8] = d_card[15:8];
  end
  modport host (output addr, ce1_n, ce2_n, reg_n, oe_n, we_n, reset,
                d_host, d_host_oe, input wait_n, d);
  modport card (input addr, ce1_n, ce2_n, reg_n, oe_n, we_n, reset,
                d, output wait_n, d_card, d_card_oe);
endinterface : pcc_if

// *** hdl/pcc_sync3.sv ***
/*
  three-flop synchroniser with agreement filter.
  assumes an asynchronous input and a single clock.
*/
`timescale 1ns/1ps
module pcc_sync3 #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         mclk_in,
  input  wire logic         arst_n_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1_r  <= INIT;
      s2_r  <= INIT;
      s3_r  <= INIT;
      q_out <= INIT;
    end else begin
      s1_r <= d_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) q_out[i] <= s3_r[i];
      end
    end
  end
endmodule : pcc_sync3

// *** hdl/pcc_card.sv ***
/*
  card end of a 16-bit pc card memory cycle, with a small common memory
  and attribute configuration byte.
  assumes the host keeps its bus rules; all pins are asynchronous.
*/
`timescale 1ns/1ps
`include "pcc_consts.svh"
// Functional notes
// - enables asserted start cycle, deasserted end it
// - host sets address, then lowers enables
// - host keeps reg_n high for common memory
// - ce1 only: byte on low lane, a0 selects
// - both enables: full 16-bit word
// - ce2 only: odd byte on upper lane
// - oe low reads, card drives enabled lanes
// - we low writes, card captures enabled lanes; attribute writes keep only the low lane, and only with ce1
// - card holds wait low until done
// - 26-bit address, three 64 mbyte spaces; card decodes only reg_n, so io cycles reach common memory
// - common memory data, attribute holds configuration
// - host reset returns configuration to reset
// - wait applies to every space alike
// - all bus inputs synchronised before use
// - highest index is most significant bit
// - wait released once data valid/accepted
module pcc_card #(
  parameter int unsigned MEM_AW     = `PCC_MEM_AW,
  parameter int unsigned ACCESS_CYC = `PCC_ACCESS_CYC
) (
  input  wire logic  mclk_in,
  input  wire logic  arst_n_in,
  pcc_if.card        bus,
  output logic [7:0] cfg_out,
  output logic       busy_out
);
  import pcc_pkg::*;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ACC  = 4'h2,
    ST_DONE = 4'h4,
    ST_END  = 4'h8
  } state_t;
  typedef struct packed {
    state_t      st;
    logic [3:0]  cnt;
    logic        wait_n;
    data_t       dout;
    logic [1:0]  doe;
    logic [7:0]  cfg;
    logic        busy;
  } card_t;
  card_t s_r;
  card_t s_nxt;
  logic [15:0] mem_lo [0:(1<<MEM_AW)-1];
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [5:0] ctl_s;
  addr_t      a_s;
  data_t      d_s;
  pcc_sync3 #(.W(6), .INIT(6'h1f)) u_ctl (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .d_in      ({bus.reset, bus.reg_n, bus.we_n, bus.oe_n, bus.ce2_n,
                 bus.ce1_n}),
    .q_out     (ctl_s)
  );
  pcc_sync3 #(.W(`PCC_ADDR_W)) u_adr (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .d_in      (bus.addr),
    .q_out     (a_s)
  );
  pcc_sync3 #(.W(`PCC_DATA_W)) u_dat (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .d_in      (bus.d),
    .q_out     (d_s)
  );
  logic ce1, ce2, oe, we, attr, rst;
  assign ce1  = ~ctl_s[0];
  assign ce2  = ~ctl_s[1];
  assign oe   = ~ctl_s[2];
  assign we   = ~ctl_s[3];
  assign attr = ~ctl_s[4];
  assign rst  = ctl_s[5];
  // ----------------------------------------
  // lane decode
  // ----------------------------------------
  logic [MEM_AW-1:0] widx;
  logic [15:0]       word;
  logic [1:0]        lanes;
  assign widx = a_s[MEM_AW:1];
  assign word = mem_lo[widx];
  always_comb begin
    lanes = 2'h0;
    if (ce1 && ce2) lanes = 2'h3;
    else if (ce1) lanes = 2'h1;
    else if (ce2) lanes = 2'h2;
  end
  // ----------------------------------------
  // cycle control
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    case (s_r.st)
      ST_IDLE: begin
        if ((ce1 || ce2) && (oe || we)) begin
          s_nxt.st     = ST_ACC;
          s_nxt.wait_n = 1'b0;
          s_nxt.cnt    = 4'(ACCESS_CYC);
          s_nxt.busy   = 1'b1;
        end
      end
      ST_ACC: begin
        if (s_r.cnt > 4'h1) s_nxt.cnt = s_r.cnt - 4'h1;
        else begin
          s_nxt.st = ST_DONE;
          if (oe) begin
            s_nxt.doe = lanes;
            if (attr) s_nxt.dout = {8'h00, s_r.cfg};
            else if (lanes == 2'h1 && a_s[0]) s_nxt.dout = {8'h00, word[15:8]};
            else s_nxt.dout = word;
          end else if (we && attr && lanes[0]) begin
            s_nxt.cfg = d_s[7:0];
          end
        end
      end
      ST_DONE: begin
        s_nxt.wait_n = 1'b1;
        s_nxt.st     = ST_END;
      end
      ST_END: begin
        if (!(ce1 || ce2)) begin
          s_nxt.st   = ST_IDLE;
          s_nxt.busy = 1'b0;
        end
        if (!(oe && (ce1 || ce2))) s_nxt.doe = 2'h0;
      end
      default: s_nxt.st = ST_IDLE;
    endcase
    if (rst) s_nxt.cfg = `PCC_CFG_RESET;
  end
  always_ff @(posedge mclk_in) begin
    if (s_r.st == ST_ACC && s_r.cnt == 4'h1 && we && !attr) begin
      if (lanes == 2'h1 && a_s[0]) mem_lo[widx][15:8] <= d_s[7:0];
      else begin
        if (lanes[0]) mem_lo[widx][7:0] <= d_s[7:0];
        if (lanes[1]) mem_lo[widx][15:8] <= d_s[15:8];
      end
    end
  end
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_r <= '{st: ST_IDLE, cnt: 4'h0, wait_n: 1'b1, dout: 16'h0000,
               doe: 2'h0, cfg: `PCC_CFG_RESET, busy: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end
  assign bus.wait_n    = s_r.wait_n;
  assign bus.d_card    = s_r.dout;
  assign bus.d_card_oe = s_r.doe;
  assign cfg_out       = s_r.cfg;
  assign busy_out      = s_r.busy;
endmodule : pcc_card

// *** hdl/pcc_host.sv ***
/*
  host socket end: runs one common or attribute memory cycle per request.
  assumes the card keeps the wait handshake.
*/
`timescale 1ns/1ps
`include "pcc_consts.svh"
module pcc_host (
  input  wire logic          mclk_in,
  input  wire logic          arst_n_in,
  pcc_if.host                bus,
  input  wire logic          req_in,
  input  wire logic          wr_in,
  input  wire logic [1:0]    be_in,
  input  wire pcc_pkg::space_t sp_in,
  input  wire pcc_pkg::addr_t addr_in,
  input  wire pcc_pkg::data_t wdata_in,
  input  wire logic          card_reset_in,
  output pcc_pkg::data_t     rdata_out,
  output logic               done_out,
  output logic               busy_out
);
  import pcc_pkg::*;
  typedef enum logic [3:0] {
    H_IDLE = 4'h1, H_SET = 4'h2, H_WAIT = 4'h4, H_END = 4'h8
  } hst_t;
  typedef struct packed {
    hst_t st; logic [3:0] cnt; addr_t a; logic ce1_n; logic ce2_n;
    logic reg_n; logic oe_n; logic we_n; data_t wd; logic doe;
    data_t rd; logic done; logic busy; logic wr; logic [1:0] be; logic rst;
  } host_t;
  host_t h_r;
  host_t h_nxt;
  logic  wait_s;
  data_t d_s;
  pcc_sync3 #(.W(1), .INIT(1'b1)) u_w (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .d_in      (bus.wait_n),
    .q_out     (wait_s)
  );
  pcc_sync3 #(.W(`PCC_DATA_W), .INIT(16'hffff)) u_d (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .d_in      (bus.d),
    .q_out     (d_s)
  );
  always_comb begin
    h_nxt      = h_r;
    h_nxt.done = 1'b0;
    h_nxt.rst  = card_reset_in;
    case (h_r.st)
      H_IDLE: if (req_in && be_in != 2'h0) begin
        h_nxt.a = addr_in;
        h_nxt.reg_n = (sp_in != SP_ATTR);
        h_nxt.wr = wr_in; h_nxt.be = be_in; h_nxt.wd = wdata_in;
        h_nxt.doe = wr_in; h_nxt.busy = 1'b1;
        h_nxt.cnt = 4'(`PCC_SETUP_CYC); h_nxt.st = H_SET;
      end
      H_SET: begin
        if (h_r.cnt > 4'h1) h_nxt.cnt = h_r.cnt - 4'h1;
        else begin
          h_nxt.ce1_n = ~h_r.be[0];
          h_nxt.ce2_n = ~h_r.be[1];
          h_nxt.oe_n = h_r.wr; h_nxt.we_n = ~h_r.wr;
          // hold past card sync, response and wait sync
          h_nxt.cnt = 4'(`PCC_WAIT_HOLD_CYC); h_nxt.st = H_WAIT;
        end
      end
      H_WAIT: begin
        if (h_r.cnt != 4'h0) h_nxt.cnt = h_r.cnt - 4'h1;
        else if (wait_s) begin
          h_nxt.rd = d_s; h_nxt.oe_n = 1'b1; h_nxt.we_n = 1'b1;
          h_nxt.st = H_END;
        end
      end
      H_END: begin
        h_nxt.ce1_n = 1'b1; h_nxt.ce2_n = 1'b1; h_nxt.doe = 1'b0;
        h_nxt.reg_n = 1'b1; h_nxt.done = 1'b1; h_nxt.busy = 1'b0;
        h_nxt.st = H_IDLE;
      end
      default: h_nxt.st = H_IDLE;
    endcase
  end
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      h_r <= '{st: H_IDLE, cnt: 4'h0, a: '0, ce1_n: 1'b1, ce2_n: 1'b1,
               reg_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, wd: '0, doe: 1'b0,
               rd: '0, done: 1'b0, busy: 1'b0, wr: 1'b0, be: 2'h0,
               rst: 1'b0};
    end else begin
      h_r <= h_nxt;
    end
  end
  assign bus.addr = h_r.a;
  assign bus.ce1_n = h_r.ce1_n;
  assign bus.ce2_n = h_r.ce2_n;
  assign bus.reg_n = h_r.reg_n;
  assign bus.oe_n = h_r.oe_n;
  assign bus.we_n = h_r.we_n;
  assign bus.reset = h_r.rst;
  assign bus.d_host = h_r.wd;
  assign bus.d_host_oe = h_r.doe;
  assign rdata_out = h_r.rd;
  assign done_out = h_r.done;
  assign busy_out = h_r.busy;
endmodule : pcc_host

// *** test/pcc_properties.sv ***
/*
  bus checks for the pc card host and card ends.
  assumes instantiation beside the interface, one clock.
*/
`timescale 1ns/1ps
module pcc_properties (
  input wire logic       mclk_in,
  input wire logic       arst_n_in,
  input wire logic       ce1_n,
  input wire logic       ce2_n,
  input wire logic       oe_n,
  input wire logic       we_n,
  input wire logic       wait_n,
  input wire logic [1:0] d_card_oe
);
  logic en;
  logic drv;
  assign en = !ce1_n || !ce2_n;
  assign drv = d_card_oe != 2'h0;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  // ---
  // cycle steps
  // ---
  sequence strobe_s;
    $fell(oe_n) || $fell(we_n);
  endsequence
  sequence stretch_s;
    !wait_n ##[1:6] wait_n;
  endsequence
  wait_start_a: assert property ($fell(wait_n) |-> en)
    else $error("wait outside cycle");
  wait_taken_a: assert property (strobe_s |-> ##[1:8] !wait_n)
    else $error("no wait after strobe");
  wait_bound_a: assert property ($fell(wait_n) |-> stretch_s)
    else $error("wait too long");
  cycle_hold_a: assert property (!wait_n |-> en && !(oe_n && we_n))
    else $error("cycle closed under wait");
  drive_cause_a: assert property ($rose(drv) |-> en && !oe_n)
    else $error("lanes driven without read");
  lane_off_a: assert property ($rose(oe_n) |-> ##6 !drv)
    else $error("lanes left driven");
  word_lanes_a: assert property (drv && !ce1_n && !ce2_n
    |-> d_card_oe == 2'h3) else $error("word lanes wrong");
  low_lane_a: assert property (drv && !ce1_n && ce2_n
    |-> d_card_oe == 2'h1) else $error("low lane wrong");
  high_lane_a: assert property (drv && ce1_n && !ce2_n
    |-> d_card_oe == 2'h2) else $error("high lane wrong");
endmodule : pcc_properties

// *** test/pc_card_memory_cycle_target_tb.sv ***
/*
  self-checking bench: host and card ends joined by the bus interface.
  assumes package, interface and both ends compiled first.
*/
`timescale 1ns/1ps
`include "pcc_consts.svh"
module pc_card_memory_cycle_target_tb;
  import pcc_pkg::*;
  logic       mclk_in, arst_n_in, req, wr, crst, done, hbusy, cbusy;
  logic [1:0] be, b;
  space_t     sp;
  addr_t      addr;
  data_t      wdata, rdata;
  logic [7:0] cfg;
  logic [7:0] mem [int];
  int         mismatches, comparisons, seed, i, rv;
  pcc_if bus ();
  pcc_card u_pcc_card (.mclk_in, .arst_n_in, .bus(bus), .cfg_out(cfg),
    .busy_out(cbusy));
  pcc_host u_pcc_host (.mclk_in, .arst_n_in, .bus(bus), .req_in(req),
    .wr_in(wr), .be_in(be), .sp_in(sp), .addr_in(addr), .wdata_in(wdata),
    .card_reset_in(crst), .rdata_out(rdata), .done_out(done),
    .busy_out(hbusy));
  pcc_properties u_pcc_properties (.mclk_in, .arst_n_in,
    .ce1_n(bus.ce1_n), .ce2_n(bus.ce2_n), .oe_n(bus.oe_n),
    .we_n(bus.we_n), .wait_n(bus.wait_n), .d_card_oe(bus.d_card_oe));
  // ---
  // checks and transfers
  // ---
  task automatic chk(input string n, input logic [15:0] e, s);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic test_done();
    if (mismatches == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done
  task automatic xfer(input logic w, input logic [1:0] m, input space_t s,
                      input addr_t a, input data_t v);
    int   n;
    logic seen;
    logic cb;
    n = 0;
    seen = 1'b0;
    cb = 1'b0;
    {wr, be, addr, wdata} = {w, m, a, v};
    sp = s;
    req = 1'b1;
    @(posedge mclk_in) #2 req = 1'b0;
    while (done !== 1'b1 && n < 80) begin
      @(posedge mclk_in) #2 n++;
      cb = cb | cbusy;
      if (!seen && !(bus.oe_n && bus.we_n)) begin
        seen = 1'b1;
        chk("ce", {14'h0, ~m}, {14'h0, bus.ce2_n, bus.ce1_n});
        chk("stb", {14'h0, w, !w}, {14'h0, bus.oe_n, bus.we_n});
        chk("reg", {15'h0, s != SP_ATTR}, {15'h0, bus.reg_n});
        chk("adr", a[25:10], bus.addr[25:10]);
        chk("hbusy", 16'h1, {15'h0, hbusy});
      end
    end
    chk("done", 16'h1, {15'h0, done});
    chk("cbusy", 16'h1, {15'h0, cb});
  endtask : xfer
  task automatic mem_op(input logic w, input logic [1:0] m, input space_t s,
                        input addr_t a, input data_t v);
    int k [2];
    k[0] = int'(a[8:0]);
    k[1] = k[0] | 1;
    xfer(w, m, s, a, v);
    for (int j = 0; j < 2; j++) begin
      if (m[j] && w)
        mem[k[j]] = v[8*j +: 8];
      else if (m[j] && mem.exists(k[j]))
        chk("rd", {8'h0, mem[k[j]]}, {8'h0, rdata[8*j +: 8]});
    end
  endtask : mem_op
  // ---
  // clock, watchdog, sequence
  // ---
  initial begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end
  initial begin
    #100us;
    chk("wdog", 16'h1, 16'h0);
    test_done();
  end
  initial begin
    seed = 51209;
    mismatches = 0;
    comparisons = 0;
    {req, wr, crst, be, addr, wdata} = '0;
    sp = SP_COMMON;
    arst_n_in = 1'b0;
    repeat (5) @(posedge mclk_in);
    #2 arst_n_in = 1'b1;
    req = 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk_in) #2;
      chk("idle", 16'h0, {12'h0, done, hbusy, cbusy,
        !(bus.ce1_n && bus.ce2_n)});
    end
    req = 1'b0;
    @(posedge mclk_in) #2;
    rv = $random(seed) | 1;
    xfer(1'b1, 2'h1, SP_ATTR, '0, rv[15:0]);
    chk("cfg", {8'h0, rv[7:0]}, {8'h0, cfg});
    xfer(1'b0, 2'h1, SP_ATTR, '0, 16'h0);
    chk("cfgrd", {8'h0, rv[7:0]}, {8'h0, rdata[7:0]});
    crst = 1'b1;
    repeat (8) @(posedge mclk_in);
    #2 crst = 1'b0;
    repeat (8) @(posedge mclk_in);
    #2 chk("cfgrst", {8'h0, `PCC_CFG_RESET}, {8'h0, cfg});
    for (i = 0; i < 60; i++) begin
      rv = $random(seed);
      b = (rv[1:0] == 2'h0) ? 2'h3 : rv[1:0];
      mem_op(rv[6], b, rv[7] ? SP_IO : SP_COMMON,
             {rv[31:15], 5'h0, rv[5:3], (b == 2'h1) & rv[2]},
             data_t'($random(seed)));
    end
    test_done();
  end
endmodule : pc_card_memory_cycle_target_tb
